// File: rtl/adcg_regs.sv
`timescale 1ns/1ps
module adcg_regs (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire adcg_pkg::adcg_req_t reg_req_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_out,
    output logic [2:0] averaging_ratio_out,
    output logic oscillator_choice_out,
    output logic [3:0] sample_div_out,
    output logic [7:0] analog_input_pin_out,
    input wire logic conv_done_in,
    output logic [2:0] conv_channel_out,
    output logic conv_valid_out,
    output logic scan_active_flag_out
);

    // ****************************************
    // state and helpers
    // ****************************************
    adcg_pkg::adcg_regs_t st_ff;
    adcg_pkg::adcg_regs_t nxt_st;
    logic [7:0] input_level_bits;
    logic [7:0] digital_output_pin;
    logic scan_active_flag;

    // ****************************************
    // pin input synchroniser
    // ****************************************
    adcg_sync u_sync (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .pin_in(pin_in),
        .pin_sync_out(input_level_bits)
    );

    // ****************************************
    // channel sequencer
    // ****************************************
    adcg_scan u_scan (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .policy_in(st_ff.cfg.policy),
        .go_in(st_ff.cfg.go),
        .mask_in(st_ff.cfg.mask),
        .fixed_in(st_ff.cfg.fixed),
        .analog_in(~st_ff.cfg.func),
        .conv_done_in(conv_done_in),
        .conv_channel_out(conv_channel_out),
        .conv_valid_out(conv_valid_out),
        .scan_active_out(scan_active_flag)
    );

    // ****************************************
    // register access and pin drive
    // ****************************************

    // output only where channel is digital and direction is out
    assign digital_output_pin = st_ff.cfg.func & st_ff.cfg.dir;

    // writes, read mux and pin drive
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rvalid = reg_req_in.rd;
        nxt_st.rdata = 8'h00;
        if (reg_req_in.wr) begin
            case (reg_req_in.addr)
                adcg_pkg::ADDR_AVG: begin
                    nxt_st.cfg.avg = reg_req_in.wdata[adcg_pkg::AVG_LSB +: 3];
                end
                adcg_pkg::ADDR_OSC: begin
                    nxt_st.cfg.osc = reg_req_in.wdata[adcg_pkg::OSC_POS];
                    nxt_st.cfg.div = reg_req_in.wdata[adcg_pkg::DIV_LSB +: 4];
                end
                adcg_pkg::ADDR_FUNC: begin
                    nxt_st.cfg.func = reg_req_in.wdata;
                end
                adcg_pkg::ADDR_DIR: begin
                    nxt_st.cfg.dir = reg_req_in.wdata;
                end
                adcg_pkg::ADDR_DRIVE: begin
                    nxt_st.cfg.drive = reg_req_in.wdata;
                end
                adcg_pkg::ADDR_LEVEL: begin
                    nxt_st.cfg.level = reg_req_in.wdata;
                end
                adcg_pkg::ADDR_SCAN: begin
                    nxt_st.cfg.go = reg_req_in.wdata[adcg_pkg::GO_POS];
                    nxt_st.cfg.policy = adcg_pkg::adcg_policy_t'(
                        reg_req_in.wdata[adcg_pkg::POLICY_LSB +: 2]);
                end
                adcg_pkg::ADDR_FIXED: begin
                    nxt_st.cfg.fixed = reg_req_in.wdata[adcg_pkg::FIXED_LSB +: 4];
                end
                adcg_pkg::ADDR_MASK: begin
                    nxt_st.cfg.mask = reg_req_in.wdata;
                end
                default: begin
                    nxt_st.cfg = st_ff.cfg; // read-only or unmapped: ignored
                end
            endcase
        end
        if (reg_req_in.rd) begin
            // reserved positions stay zero
            case (reg_req_in.addr)
                adcg_pkg::ADDR_STATUS: begin
                    nxt_st.rdata[adcg_pkg::STATUS_ONE_POS] = 1'b1;
                    nxt_st.rdata[adcg_pkg::ACTIVE_POS] = scan_active_flag;
                end
                adcg_pkg::ADDR_AVG: begin
                    nxt_st.rdata[adcg_pkg::AVG_LSB +: 3] = st_ff.cfg.avg;
                end
                adcg_pkg::ADDR_OSC: begin
                    nxt_st.rdata[adcg_pkg::OSC_POS] = st_ff.cfg.osc;
                    nxt_st.rdata[adcg_pkg::DIV_LSB +: 4] = st_ff.cfg.div;
                end
                adcg_pkg::ADDR_FUNC: begin
                    nxt_st.rdata = st_ff.cfg.func;
                end
                adcg_pkg::ADDR_DIR: begin
                    nxt_st.rdata = st_ff.cfg.dir;
                end
                adcg_pkg::ADDR_DRIVE: begin
                    nxt_st.rdata = st_ff.cfg.drive;
                end
                adcg_pkg::ADDR_LEVEL: begin
                    nxt_st.rdata = st_ff.cfg.level;
                end
                adcg_pkg::ADDR_INPUT: begin
                    nxt_st.rdata = input_level_bits;
                end
                adcg_pkg::ADDR_SCAN: begin
                    nxt_st.rdata[adcg_pkg::GO_POS] = st_ff.cfg.go;
                    nxt_st.rdata[adcg_pkg::POLICY_LSB +: 2] = st_ff.cfg.policy;
                end
                adcg_pkg::ADDR_FIXED: begin
                    nxt_st.rdata[adcg_pkg::FIXED_LSB +: 4] = st_ff.cfg.fixed;
                end
                adcg_pkg::ADDR_MASK: begin
                    nxt_st.rdata = st_ff.cfg.mask;
                end
                default: begin
                    nxt_st.rdata = 8'h00; // unmapped reads zero
                end
            endcase
        end
        // push-pull drives both levels, open-drain only pulls low
        nxt_st.pin_oe = digital_output_pin & (st_ff.cfg.drive | ~st_ff.cfg.level);
        nxt_st.pin_out = digital_output_pin & st_ff.cfg.drive & st_ff.cfg.level;
    end

    // state register
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_ff <= '{cfg: adcg_pkg::CFG_RST, pin_out: 8'h00, pin_oe: 8'h00,
                rdata: 8'h00, rvalid: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign reg_rdata_out = st_ff.rdata;
    assign reg_rvalid_out = st_ff.rvalid;
    assign pin_out = st_ff.pin_out;
    assign pin_oe_out = st_ff.pin_oe;
    assign averaging_ratio_out = st_ff.cfg.avg;
    assign oscillator_choice_out = st_ff.cfg.osc;
    assign sample_div_out = st_ff.cfg.div;
    assign analog_input_pin_out = ~st_ff.cfg.func;
    assign scan_active_flag_out = scan_active_flag;

    // ****************************************
    // checks
    // ****************************************
    sequence s_wr_avg;
        reg_req_in.wr && reg_req_in.addr == adcg_pkg::ADDR_AVG;
    endsequence

    sequence s_wr_osc;
        reg_req_in.wr && reg_req_in.addr == adcg_pkg::ADDR_OSC;
    endsequence

    sequence s_rd_input;
        reg_req_in.rd && reg_req_in.addr == adcg_pkg::ADDR_INPUT;
    endsequence

    property p_avg_store;
        @(posedge ref_clk_in) disable iff (!rst_b_in)
        s_wr_avg |=> averaging_ratio_out == $past(reg_req_in.wdata[2:0]);
    endproperty

    avg_field_a: assert property (p_avg_store) else $error("averaging ratio not stored");
    osc_choice_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        s_wr_osc |=> oscillator_choice_out == $past(reg_req_in.wdata[4]))
        else $error("oscillator choice not stored");
    div_field_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        s_wr_osc |=> sample_div_out == $past(reg_req_in.wdata[3:0]))
        else $error("sample divider not stored");
    div_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        !(reg_req_in.wr && reg_req_in.addr == adcg_pkg::ADDR_OSC) |=> $stable(sample_div_out))
        else $error("sample divider changed without write");
    pin_digital_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        ##1 (pin_oe_out & ~$past(st_ff.cfg.func & st_ff.cfg.dir)) == 8'h00)
        else $error("analog or input channel driven");
    out_level_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        ##1 (((pin_out ^ $past(st_ff.cfg.level)) & pin_oe_out) == 8'h00))
        else $error("driven pin not at its output level");
    drain_low_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        ##1 (((pin_oe_out & pin_out & ~$past(st_ff.cfg.drive)) == 8'h00)
        && (($past(digital_output_pin & st_ff.cfg.drive) & ~pin_oe_out) == 8'h00)))
        else $error("drive type enable wrong");
    gpi_read_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        s_rd_input |=> reg_rvalid_out && reg_rdata_out == $past(input_level_bits))
        else $error("input level read wrong");
    rsvd_zero_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (reg_req_in.rd && reg_req_in.addr == adcg_pkg::ADDR_SCAN) |=> reg_rdata_out[7:5] == 3'h0
        && reg_rdata_out[3:2] == 2'h0) else $error("reserved bits not zero");
    flag_read_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (reg_req_in.rd && reg_req_in.addr == adcg_pkg::ADDR_STATUS) |=>
        reg_rdata_out[6] == $past(scan_active_flag)) else $error("scan flag read wrong");

endmodule

// File: rtl/adcg_pkg.sv
// Summary of operation
// - 3-bit averaging ratio, none up to 128
// - bit 4 picks high-speed or low-power oscillator
// - 4-bit sample-rate divider, resets to 0100b
// - per channel: analog input or digital pin
// - per pin direction: input or output
// - per output drive: open-drain or push-pull
// - outputs drive their output-level bit, open-drain ones only when it is low
// - input register reads live pin levels
// - scan go starts/stops ascending auto scan
// - scan policy manual, auto, on-the-fly, reserved; on-the-fly offers no channel here, like reserved
// - manual converts fixed channel number, top bit reserved
// - auto scan includes only masked channels
// - scan active flag shows sequence in progress
package adcg_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_AVG = 8'h03;
    localparam logic [7:0] ADDR_OSC = 8'h04;
    localparam logic [7:0] ADDR_FUNC = 8'h05;
    localparam logic [7:0] ADDR_DIR = 8'h07;
    localparam logic [7:0] ADDR_DRIVE = 8'h09;
    localparam logic [7:0] ADDR_LEVEL = 8'h0B;
    localparam logic [7:0] ADDR_INPUT = 8'h0D;
    localparam logic [7:0] ADDR_SCAN = 8'h10;
    localparam logic [7:0] ADDR_FIXED = 8'h11;
    localparam logic [7:0] ADDR_MASK = 8'h12;

    // ****************************************
    // field positions
    // ****************************************
    localparam int AVG_LSB = 0;
    localparam int OSC_POS = 4;
    localparam int DIV_LSB = 0;
    localparam int GO_POS = 4;
    localparam int POLICY_LSB = 0;
    localparam int FIXED_LSB = 0;
    localparam int ACTIVE_POS = 6;
    localparam int STATUS_ONE_POS = 7;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        POL_MANUAL,
        POL_AUTO,
        POL_FLY,
        POL_RSVD
    } adcg_policy_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } adcg_req_t;

    typedef struct packed {
        logic [2:0] avg;
        logic osc;
        logic [3:0] div;
        logic [7:0] func;
        logic [7:0] dir;
        logic [7:0] drive;
        logic [7:0] level;
        logic go;
        adcg_policy_t policy;
        logic [3:0] fixed;
        logic [7:0] mask;
    } adcg_cfg_t;

    typedef struct packed {
        adcg_cfg_t cfg;
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
        logic [7:0] rdata;
        logic rvalid;
    } adcg_regs_t;

    typedef struct packed {
        logic active;
        logic valid;
        logic [2:0] ch;
    } adcg_scan_t;

    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
    } adcg_sync_t;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [2:0] RST_AVG = 3'h0;
    localparam logic RST_OSC = 1'b0;
    localparam logic [3:0] RST_DIV = 4'h4;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_FIXED = 4'h0;
    localparam adcg_cfg_t CFG_RST = '{avg: RST_AVG, osc: RST_OSC, div: RST_DIV,
        func: RST_BYTE, dir: RST_BYTE, drive: RST_BYTE, level: RST_BYTE, go: 1'b0,
        policy: POL_MANUAL, fixed: RST_FIXED, mask: RST_BYTE};

endpackage

// File: rtl/adcg_sync.sv
`timescale 1ns/1ps
module adcg_sync (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_sync_out
);

    // ****************************************
    // two-stage pin synchroniser
    // ****************************************
    adcg_pkg::adcg_sync_t st_ff;
    adcg_pkg::adcg_sync_t nxt_st;

    // first stage feeds only the second
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = pin_in;
        nxt_st.s2 = st_ff.s1;
    end

    // state register
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pin_sync_out = st_ff.s2;

endmodule

// File: rtl/adcg_scan.sv
`timescale 1ns/1ps
module adcg_scan (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire adcg_pkg::adcg_policy_t policy_in,
    input wire logic go_in,
    input wire logic [7:0] mask_in,
    input wire logic [3:0] fixed_in,
    input wire logic [7:0] analog_in,
    input wire logic conv_done_in,
    output logic [2:0] conv_channel_out,
    output logic conv_valid_out,
    output logic scan_active_out
);

    // ****************************************
    // channel sequencer
    // ****************************************
    adcg_pkg::adcg_scan_t st_ff;
    adcg_pkg::adcg_scan_t nxt_st;
    logic [7:0] avail;
    logic [7:0] avail_q;

    // next enabled channel above from, wrapping
    function automatic logic [2:0] next_ch(input logic [7:0] av, input logic [2:0] from);
        logic [2:0] idx;
        logic [2:0] res;
        res = from;
        for (int k = 8; k >= 1; k--) begin
            idx = from + 3'(k);
            if (av[idx]) begin
                res = idx;
            end
        end
        return res;
    endfunction

    assign avail = mask_in & analog_in;

    // sequencing decisions per policy
    always_comb begin
        nxt_st = st_ff;
        if (policy_in == adcg_pkg::POL_AUTO && go_in && avail != 8'h00) begin
            nxt_st.valid = 1'b1;
            nxt_st.active = 1'b1;
            if (!st_ff.active) begin
                nxt_st.ch = next_ch(avail, 3'h7); // ascending from lowest
            end else if (conv_done_in || !avail[st_ff.ch]) begin
                nxt_st.ch = next_ch(avail, st_ff.ch);
            end
        end else begin
            nxt_st.active = 1'b0;
            nxt_st.ch = fixed_in[2:0];
            nxt_st.valid = (policy_in == adcg_pkg::POL_MANUAL) && !fixed_in[3];
        end
    end

    // state register
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // helper copy for checks
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            avail_q <= 8'h00;
        end else begin
            avail_q <= avail;
        end
    end

    assign conv_channel_out = st_ff.ch;
    assign conv_valid_out = st_ff.valid;
    assign scan_active_out = st_ff.active;

    // ****************************************
    // checks
    // ****************************************
    sequence s_scan_begin;
        $rose(st_ff.active);
    endsequence

    scan_stop_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        !go_in |=> !scan_active_out) else $error("scan kept running after stop");
    scan_first_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        s_scan_begin |-> conv_channel_out == next_ch(avail_q, 3'h7))
        else $error("scan did not start at lowest channel");
    scan_mask_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        scan_active_out |-> avail_q[conv_channel_out]) else $error("unmasked channel scanned");
    manual_ch_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (policy_in == adcg_pkg::POL_MANUAL && !fixed_in[3]) |=>
        (conv_valid_out && conv_channel_out == $past(fixed_in[2:0])))
        else $error("manual channel not selected");
    fly_idle_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (policy_in == adcg_pkg::POL_FLY || policy_in == adcg_pkg::POL_RSVD) |=> !conv_valid_out)
        else $error("channel offered outside manual or auto");

endmodule

// File: test/adcg_host.sv
`timescale 1ns/1ps
// ********************************
// host and board model
// ********************************
module adcg_host (
    input wire logic ref_clk_in,
    output adcg_pkg::adcg_req_t req_out,
    input wire logic [7:0] rdata_in,
    input wire logic rvalid_in,
    input wire logic [7:0] drv_in,
    input wire logic [7:0] oe_in,
    output logic [7:0] level_out
);
    logic [7:0] ext_level;

    // device drives enabled pins, the board sets the rest
    assign level_out = (oe_in & drv_in) | (~oe_in & ext_level);

    // idle bus, pins pulled high
    initial begin
        ext_level = 8'hFF;
        req_out = '0;
    end

    // one access launched after an edge, taken at the next one
    task automatic access(input logic wr, input logic [7:0] addr,
            input logic [7:0] wdata, output logic [7:0] rdata);
        int n;
        @(posedge ref_clk_in);
        #1;
        req_out = '{wr: wr, rd: ~wr, addr: addr, wdata: wdata};
        @(posedge ref_clk_in);
        #1;
        req_out = '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
        n = 0;
        while (!wr && rvalid_in !== 1'b1 && n < 3) begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
        rdata = (rvalid_in === 1'b1) ? rdata_in : 8'hXX;
    endtask
endmodule

// File: test/adcg_regs_tb_top.sv
`timescale 1ns/1ps
// ********************************
// register bank bench
// ********************************
module adcg_regs_tb_top;
    localparam logic [7:0] ADDRS [9] = '{8'h03, 8'h04, 8'h05, 8'h07, 8'h09, 8'h0B,
        8'h10, 8'h11, 8'h12};
    localparam logic [7:0] RSTS [9] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00};
    localparam logic [7:0] MASKS [9] = '{8'h07, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'h13, 8'h0F, 8'hFF};

    logic ref_clk_in;
    logic rst_b_in;
    logic conv_done;
    adcg_pkg::adcg_req_t req;
    logic [7:0] rdata, pins, drv, oe, analog;
    logic rvalid, osc, valid, active;
    logic [2:0] avg, ch;
    logic [3:0] div;
    int err_count, check_count, cycles;
    logic [31:0] seed;

    adcg_regs i_adcg_regs (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .reg_req_in(req),
        .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid),
        .pin_in(pins),
        .pin_out(drv),
        .pin_oe_out(oe),
        .averaging_ratio_out(avg),
        .oscillator_choice_out(osc),
        .sample_div_out(div),
        .analog_input_pin_out(analog),
        .conv_done_in(conv_done),
        .conv_channel_out(ch),
        .conv_valid_out(valid),
        .scan_active_flag_out(active)
    );

    adcg_host i_adcg_host (
        .ref_clk_in(ref_clk_in),
        .req_out(req),
        .rdata_in(rdata),
        .rvalid_in(rvalid),
        .drv_in(drv),
        .oe_in(oe),
        .level_out(pins)
    );

    // clock and cycle limit
    initial ref_clk_in = 1'b0;
    always #2.5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            stop_test();
        end
    end

    // xorshift step
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // helpers
    task automatic rnd(output logic [7:0] v);
        seed = xs(seed);
        v = seed[7:0];
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [7:0] d;
        i_adcg_host.access(1'b1, a, v, d);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        i_adcg_host.access(1'b0, a, 8'h00, v);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %02h seen %02h", name, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        logic [7:0] d, f, dr, ty, lv, ex, oe_e, v;
        seed = 32'd95;
        rst_b_in = 1'b0;
        conv_done = 1'b0;
        tick(2);
        rst_b_in = 1'b1;
        check("div", {4'h0, div}, 8'h04);
        check("analog", analog, 8'hFF);
        check("oe", oe, 8'h00);
        for (int i = 0; i < 9; i++) begin
            rd(ADDRS[i], d);
            check("reset", d, RSTS[i]);
        end
        rd(8'h00, d);
        check("status", d, 8'h80);
        $display("test reset done");
        // averaging codes, oscillator choice, readback
        for (int c = 0; c < 8; c++) begin
            wr(8'h03, {5'h1F, c[2:0]});
            tick(1);
            check("avg", {5'h0, avg}, {5'h0, c[2:0]});
        end
        for (int c = 0; c < 2; c++) begin
            rnd(v);
            wr(8'h04, {v[7:5], c[0], v[3:0]});
            tick(1);
            check("osc", {3'h0, osc, div}, {3'h0, c[0], v[3:0]});
        end
        repeat (4) begin
            for (int i = 0; i < 9; i++) begin
                rnd(v);
                wr(ADDRS[i], v);
                rd(ADDRS[i], d);
                check("readback", d, v & MASKS[i]);
            end
        end
        wr(8'h20, 8'h5A);
        rd(8'h20, d);
        check("unmapped", d, 8'h00);
        $display("test access done");
        // pin modes, random with a fixed first case
        for (int i = 0; i < 10; i++) begin
            rnd(f);
            rnd(dr);
            rnd(ty);
            rnd(lv);
            rnd(ex);
            if (i == 0) begin
                f = 8'h0F;
                dr = 8'hFF;
                ty = 8'h33;
                lv = 8'h55;
                ex = 8'h00;
            end
            i_adcg_host.ext_level = ex;
            wr(8'h05, f);
            wr(8'h07, dr);
            wr(8'h09, ty);
            wr(8'h0B, lv);
            tick(2);
            oe_e = f & dr & (ty | ~lv);
            check("pin_oe", oe, oe_e);
            check("pin_drv", drv, f & dr & ty & lv);
            check("analog", analog, ~f);
            wr(8'h0D, ~ex);
            tick(3);
            rd(8'h0D, d);
            check("input", d, (oe_e & ty & lv) | (~oe_e & ex));
        end
        $display("test pins done");
        // auto scan over masked analog channels
        wr(8'h10, 8'h00); // stop any scan left by random writes
        wr(8'h05, 8'h02);
        wr(8'h12, 8'h0B);
        wr(8'h10, 8'h11);
        tick(4);
        check("active", {7'h0, active}, 8'h01);
        check("chan", {5'h0, ch}, 8'h00);
        for (int i = 0; i < 3; i++) begin
            conv_done = 1'b1;
            tick(1);
            conv_done = 1'b0;
            tick(3);
            check("next", {5'h0, ch}, (i == 1) ? 8'h00 : 8'h03);
        end
        rd(8'h00, d);
        check("status", d, 8'hC0);
        wr(8'h10, 8'h01);
        tick(3);
        check("stop", {7'h0, active}, 8'h00);
        // every policy code, then manual channel numbers
        wr(8'h11, 8'h05);
        for (int p = 0; p < 4; p++) begin
            wr(8'h10, {6'h0, p[1:0]});
            tick(3);
            if (p != 1) begin
                check("valid", {7'h0, valid}, {7'h0, p == 0});
            end else begin
                check("idle", {7'h0, active}, 8'h00);
            end
        end
        wr(8'h10, 8'h00);
        tick(3);
        check("manual", {4'h0, valid, ch}, 8'h0D);
        wr(8'h11, 8'h0D);
        tick(3);
        check("rsvd_ch", {7'h0, valid}, 8'h00);
        $display("test scan done");
        stop_test();
    end
endmodule
